/* File: rtl/spp_params.svh */
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

`define SPP_CLK_HZ 20000000
`define SPP_TICK_MS 100
`define SPP_TICK_CYCLES ((`SPP_CLK_HZ / 1000) * `SPP_TICK_MS)
`define SPP_TICKS_PER_S 24'h00000a
`define SPP_TICKS_PER_MIN 24'h000258

`define SPP_A_PROG 8'h00
`define SPP_A_RAMP 8'h01
`define SPP_A_FREQ2 8'h02
`define SPP_A_FREQ8 8'h08
`define SPP_A_TMR1 8'h09
`define SPP_A_TMR8 8'h10
`define SPP_A_RESUME 8'h11
`define SPP_A_OVS 8'h12
`define SPP_A_ACCL 8'h13
`define SPP_A_STDL 8'h14
`define SPP_A_DECL 8'h15
`define SPP_A_OTMD 8'h16
`define SPP_A_OTLV 8'h17
`define SPP_A_OTTM 8'h18
`define SPP_A_AUXN 8'h19
`define SPP_A_ALT 8'h1a
`define SPP_A_LOCK 8'h1b
`define SPP_A_HST 8'h1c
`define SPP_A_STS 8'h1d
`define SPP_A_MASK 8'h1e
`define SPP_A_STATE 8'h1f

`define SPP_PROG_INTERNAL 3'h4

`define SPP_EV_ALARM 0
`define SPP_EV_TRIP 1
`define SPP_EV_STEP 2
`define SPP_EV_SWAP 3
`define SPP_EV_STALL 4
`define SPP_EV_W 5

`define SPP_DEF_PROG 3'h0
`define SPP_DEF_RAMP 16'h0000
`define SPP_DEF_FREQ2 16'h05dc
`define SPP_DEF_FREQ3 16'h07d0
`define SPP_DEF_FREQ4 16'h09c4
`define SPP_DEF_FREQ5 16'h0bb8
`define SPP_DEF_FREQ6 16'h0dac
`define SPP_DEF_FREQ7 16'h0fa0
`define SPP_DEF_FREQ8 16'h0032
`define SPP_DEF_TMR12 16'h0064
`define SPP_DEF_TMRX 16'h0000
`define SPP_DEF_RESUME 1'h0
`define SPP_DEF_OVS 1'h1
`define SPP_DEF_ACCL 8'h96
`define SPP_DEF_STDL 8'h00
`define SPP_DEF_DECL 8'h96
`define SPP_DEF_OTMD 2'h0
`define SPP_DEF_OTLV 8'h00
`define SPP_DEF_OTTM 8'h0a
`define SPP_DEF_AUXN 2'h0
`define SPP_DEF_ALT 16'h003c
`define SPP_DEF_LOCK 8'h05
`define SPP_DEF_HST 8'h3c

`endif

/* File: rtl/spp_pkg.sv */
package spp_pkg;
  typedef logic [23:0] spp_cnt_t;
  typedef enum logic [1:0] {
    SPP_SEQ_IDLE = 2'h0,
    SPP_SEQ_RUN = 2'h1,
    SPP_SEQ_HOLD = 2'h3
  } spp_seq_t;
  typedef enum logic [1:0] {
    SPP_PMP_OFF = 2'h0,
    SPP_PMP_WAIT = 2'h1,
    SPP_PMP_DUTY = 2'h3,
    SPP_PMP_LOCK = 2'h2
  } spp_pmp_t;
endpackage

/* File: rtl/spp_tmr_if.sv */
`timescale 1ns/10ps
interface spp_tmr_if;
  logic tick;
  logic en;
  logic clr;
  spp_pkg::spp_cnt_t cnt;
  modport ctl (output tick, output en, output clr, input cnt);
  modport tmr (input tick, input en, input clr, output cnt);
endinterface

/* File: rtl/spp_tick_cnt.sv */
`timescale 1ns/10ps
module spp_tick_cnt (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  spp_tmr_if.tmr t
);
  spp_pkg::spp_cnt_t cnt_q;

  // saturates so long waits never wrap back into a false match
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= 24'h000000;
    end else if (t.clr) begin
      cnt_q <= 24'h000000;
    end else if (t.en && t.tick && cnt_q != 24'hffffff) begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

  assign t.cnt = cnt_q;
endmodule // spp_tick_cnt

/* File: rtl/spp_top.sv */
`timescale 1ns/10ps
`include "spp_params.svh"
module spp_top #(
  parameter int unsigned TICK_CYCLES = `SPP_TICK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  input wire logic run_in,
  input wire logic fault_in,
  input wire logic accel_in,
  input wire logic steady_in,
  input wire logic decel_in,
  input wire logic freq_reached_in,
  input wire logic high_speed_in,
  input wire logic [7:0] current_pct_in,
  input wire logic dcbus_over_in,
  input wire logic [15:0] main_freq_in,
  output logic [1:0] ramp_pair_out,
  output logic [15:0] step_freq_out,
  output logic [2:0] step_index_out,
  output logic accel_hold_out,
  output logic steady_lower_out,
  output logic decel_hold_out,
  output logic ot_alarm_out,
  output logic ot_trip_out,
  output logic drive_enable_out,
  output logic [1:0] pump_contact_out,
  output logic irq_out
);
  logic [2:0] prog_q;
  logic [15:0] ramp_word_q;
  logic [15:0] freq_q [7:1];
  logic [15:0] tmr_q [8];
  logic resume_q, ovs_q;
  logic [7:0] accl_q, stdl_q, decl_q, otlv_q, ottm_q, lock_q, hst_q;
  logic [1:0] otmd_q, auxn_q;
  logic [15:0] alt_q;
  logic [`SPP_EV_W-1:0] sts_q, mask_q, ev;
  logic [15:0] rd_val, rd_q;
  logic [23:0] tick_cnt_q;
  logic tick;
  logic dc_s1_q, dc_s2_q;
  spp_pkg::spp_seq_t seq_q, seq_d;
  logic [2:0] step_q, step_d;
  logic sclr, adv, run_ok, step_done, any_nz;
  logic [1:0] ramp_q;
  logic [15:0] sfreq_q;
  logic ot_act, alarm_q, trip_q, trip_set, alarm_nx;
  logic acc_q, std_q, dec_q, stall_prev_q;
  spp_pkg::spp_pmp_t pst_q, pst_d;
  logic duty_q, duty_d, pclr, pswap;
  logic [1:0] pump_q;
  logic [23:0] hs_lim, alt_lim, lock_lim;
  logic [2:0] w_fidx, w_tidx, r_fidx, r_tidx;

  spp_tmr_if step_if ();
  spp_tmr_if ot_if ();
  spp_tmr_if pmp_if ();

  spp_tick_cnt u_step_tmr (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .t(step_if));
  spp_tick_cnt u_ot_tmr (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .t(ot_if));
  spp_tick_cnt u_pmp_tmr (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .t(pmp_if));

  function automatic logic [15:0] def_freq(input int i);
    logic [15:0] v;
    v = `SPP_DEF_FREQ8;
    case (i)
      1: v = `SPP_DEF_FREQ2;
      2: v = `SPP_DEF_FREQ3;
      3: v = `SPP_DEF_FREQ4;
      4: v = `SPP_DEF_FREQ5;
      5: v = `SPP_DEF_FREQ6;
      6: v = `SPP_DEF_FREQ7;
      default: v = `SPP_DEF_FREQ8;
    endcase
    return v;
  endfunction

  // first step at (when incl is set) or after the start whose timer is nonzero
  function automatic logic [2:0] pick_step(input logic [2:0] from, input logic incl);
    logic [2:0] res;
    logic [2:0] c;
    logic hit;
    res = incl ? from : 3'(from + 3'h1);
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      c = 3'(from + 3'(i) + {2'h0, ~incl});
      if (!hit && tmr_q[c] != 16'h0000) begin
        res = c;
        hit = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] freq_of(input logic [2:0] s);
    return (s == 3'h0) ? main_freq_in : freq_q[s];
  endfunction

  assign w_fidx = 3'(addr_in - `SPP_A_FREQ2 + 8'h01);
  assign w_tidx = 3'(addr_in - `SPP_A_TMR1);
  assign r_fidx = w_fidx;
  assign r_tidx = w_tidx;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_q <= `SPP_DEF_PROG;
      ramp_word_q <= `SPP_DEF_RAMP;
      for (int i = 1; i < 8; i++) begin
        freq_q[i] <= def_freq(i);
      end
      for (int i = 0; i < 8; i++) begin
        tmr_q[i] <= (i < 2) ? `SPP_DEF_TMR12 : `SPP_DEF_TMRX;
      end
      resume_q <= `SPP_DEF_RESUME;
      ovs_q <= `SPP_DEF_OVS;
      accl_q <= `SPP_DEF_ACCL;
      stdl_q <= `SPP_DEF_STDL;
      decl_q <= `SPP_DEF_DECL;
      otmd_q <= `SPP_DEF_OTMD;
      otlv_q <= `SPP_DEF_OTLV;
      ottm_q <= `SPP_DEF_OTTM;
      auxn_q <= `SPP_DEF_AUXN;
      alt_q <= `SPP_DEF_ALT;
      lock_q <= `SPP_DEF_LOCK;
      hst_q <= `SPP_DEF_HST;
      mask_q <= '0;
    end else if (wr_in) begin
      if (addr_in == `SPP_A_PROG) begin
        prog_q <= wr_data_in[2:0];
      end else if (addr_in == `SPP_A_RAMP) begin
        ramp_word_q <= wr_data_in;
      end else if (addr_in >= `SPP_A_FREQ2 && addr_in <= `SPP_A_FREQ8) begin
        freq_q[w_fidx] <= wr_data_in;
      end else if (addr_in >= `SPP_A_TMR1 && addr_in <= `SPP_A_TMR8) begin
        tmr_q[w_tidx] <= wr_data_in;
      end else if (addr_in == `SPP_A_RESUME) begin
        resume_q <= wr_data_in[0];
      end else if (addr_in == `SPP_A_OVS) begin
        ovs_q <= wr_data_in[0];
      end else if (addr_in == `SPP_A_ACCL) begin
        accl_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_STDL) begin
        stdl_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_DECL) begin
        decl_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_OTMD) begin
        otmd_q <= wr_data_in[1:0];
      end else if (addr_in == `SPP_A_OTLV) begin
        otlv_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_OTTM) begin
        ottm_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_AUXN) begin
        auxn_q <= wr_data_in[1:0];
      end else if (addr_in == `SPP_A_ALT) begin
        alt_q <= wr_data_in;
      end else if (addr_in == `SPP_A_LOCK) begin
        lock_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_HST) begin
        hst_q <= wr_data_in[7:0];
      end else if (addr_in == `SPP_A_MASK) begin
        mask_q <= wr_data_in[`SPP_EV_W-1:0];
      end
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    if (addr_in == `SPP_A_PROG) begin
      rd_val = {13'h0000, prog_q};
    end else if (addr_in == `SPP_A_RAMP) begin
      rd_val = ramp_word_q;
    end else if (addr_in >= `SPP_A_FREQ2 && addr_in <= `SPP_A_FREQ8) begin
      rd_val = freq_q[r_fidx];
    end else if (addr_in >= `SPP_A_TMR1 && addr_in <= `SPP_A_TMR8) begin
      rd_val = tmr_q[r_tidx];
    end else if (addr_in == `SPP_A_RESUME) begin
      rd_val = {15'h0000, resume_q};
    end else if (addr_in == `SPP_A_OVS) begin
      rd_val = {15'h0000, ovs_q};
    end else if (addr_in == `SPP_A_ACCL) begin
      rd_val = {8'h00, accl_q};
    end else if (addr_in == `SPP_A_STDL) begin
      rd_val = {8'h00, stdl_q};
    end else if (addr_in == `SPP_A_DECL) begin
      rd_val = {8'h00, decl_q};
    end else if (addr_in == `SPP_A_OTMD) begin
      rd_val = {14'h0000, otmd_q};
    end else if (addr_in == `SPP_A_OTLV) begin
      rd_val = {8'h00, otlv_q};
    end else if (addr_in == `SPP_A_OTTM) begin
      rd_val = {8'h00, ottm_q};
    end else if (addr_in == `SPP_A_AUXN) begin
      rd_val = {14'h0000, auxn_q};
    end else if (addr_in == `SPP_A_ALT) begin
      rd_val = alt_q;
    end else if (addr_in == `SPP_A_LOCK) begin
      rd_val = {8'h00, lock_q};
    end else if (addr_in == `SPP_A_HST) begin
      rd_val = {8'h00, hst_q};
    end else if (addr_in == `SPP_A_STS) begin
      rd_val = {11'h000, sts_q};
    end else if (addr_in == `SPP_A_MASK) begin
      rd_val = {11'h000, mask_q};
    end else if (addr_in == `SPP_A_STATE) begin
      rd_val = {4'h0, trip_q, alarm_q, pump_q, duty_q, pst_q, seq_q, step_q};
    end
  end

  // unread cycles return zero so stale data never looks valid
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= rd_in ? rd_val : 16'h0000;
    end
  end

  // a new event wins over a same-cycle write-one clear
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sts_q <= '0;
    end else if (wr_in && addr_in == `SPP_A_STS) begin
      sts_q <= (sts_q & ~wr_data_in[`SPP_EV_W-1:0]) | ev;
    end else begin
      sts_q <= sts_q | ev;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt_q <= 24'h000000;
    end else if (tick) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end
  assign tick = (tick_cnt_q == 24'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dc_s1_q <= 1'b0;
      dc_s2_q <= 1'b0;
    end else begin
      dc_s1_q <= dcbus_over_in;
      dc_s2_q <= dc_s1_q;
    end
  end

  // program step sequencer
  assign run_ok = run_in && !fault_in && !trip_q && (prog_q == `SPP_PROG_INTERNAL);
  assign step_done = (step_if.cnt >= {8'h00, tmr_q[step_q]});
  always_comb begin
    seq_d = seq_q;
    step_d = step_q;
    sclr = 1'b0;
    adv = 1'b0;
    case (seq_q)
      spp_pkg::SPP_SEQ_IDLE: begin
        sclr = 1'b1;
        if (run_ok) begin
          seq_d = spp_pkg::SPP_SEQ_RUN;
          step_d = pick_step(3'h0, 1'b1);
        end
      end
      spp_pkg::SPP_SEQ_RUN: begin
        if (!run_ok) begin
          if (resume_q) begin
            seq_d = spp_pkg::SPP_SEQ_HOLD;
          end else begin
            seq_d = spp_pkg::SPP_SEQ_IDLE;
            step_d = 3'h0;
            sclr = 1'b1;
          end
        end else if (step_done) begin
          step_d = pick_step(step_q, 1'b0);
          sclr = 1'b1;
          adv = 1'b1;
        end
      end
      spp_pkg::SPP_SEQ_HOLD: begin
        if (!resume_q) begin
          seq_d = spp_pkg::SPP_SEQ_IDLE;
          step_d = 3'h0;
          sclr = 1'b1;
        end else if (run_ok) begin
          seq_d = spp_pkg::SPP_SEQ_RUN;
        end
      end
      default: begin
        seq_d = spp_pkg::SPP_SEQ_IDLE;
        sclr = 1'b1;
      end
    endcase
  end
  assign step_if.tick = tick;
  assign step_if.en = (seq_q == spp_pkg::SPP_SEQ_RUN);
  assign step_if.clr = sclr;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seq_q <= spp_pkg::SPP_SEQ_IDLE;
      step_q <= 3'h0;
      ramp_q <= 2'h0;
      sfreq_q <= 16'h0000;
    end else begin
      seq_q <= seq_d;
      step_q <= step_d;
      if (seq_d == spp_pkg::SPP_SEQ_RUN) begin
        ramp_q <= ramp_word_q[{step_d, 1'b0} +: 2];
        sfreq_q <= freq_of(step_d);
      end else begin
        ramp_q <= 2'h0;
        sfreq_q <= main_freq_in;
      end
    end
  end

  // stall prevention
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_q <= 1'b0;
      std_q <= 1'b0;
      dec_q <= 1'b0;
      stall_prev_q <= 1'b0;
    end else begin
      acc_q <= accel_in && accl_q != 8'h00 && current_pct_in > accl_q;
      std_q <= steady_in && stdl_q != 8'h00 && current_pct_in > stdl_q;
      dec_q <= decel_in && ovs_q && dc_s2_q;
      stall_prev_q <= acc_q || std_q || dec_q;
    end
  end

  // over-torque
  assign ot_act = otlv_q != 8'h00 && run_in && !trip_q && (otmd_q[1] || freq_reached_in)
    && current_pct_in > otlv_q;
  assign alarm_nx = ot_act && ({ot_if.cnt, 1'b0} > 25'(ottm_q));
  assign trip_set = ot_act && otmd_q[0] && ot_if.cnt > 24'(ottm_q);
  assign ot_if.tick = tick;
  assign ot_if.en = ot_act;
  assign ot_if.clr = !ot_act;

  // trip holds until the operator drops the run command
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      alarm_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      alarm_q <= alarm_nx;
      if (trip_set) begin
        trip_q <= 1'b1;
      end else if (!run_in) begin
        trip_q <= 1'b0;
      end
    end
  end

  // auxiliary pumps
  assign hs_lim = 24'(hst_q) * `SPP_TICKS_PER_S;
  assign alt_lim = 24'(alt_q) * `SPP_TICKS_PER_MIN;
  assign lock_lim = 24'(lock_q) * `SPP_TICKS_PER_S;
  always_comb begin
    pst_d = pst_q;
    duty_d = duty_q;
    pclr = 1'b0;
    pswap = 1'b0;
    if (auxn_q == 2'h0 || !run_in) begin
      pst_d = spp_pkg::SPP_PMP_OFF;
      pclr = 1'b1;
    end else begin
      case (pst_q)
        spp_pkg::SPP_PMP_OFF: begin
          pclr = 1'b1;
          if (high_speed_in) begin
            pst_d = spp_pkg::SPP_PMP_WAIT;
          end
        end
        spp_pkg::SPP_PMP_WAIT: begin
          if (!high_speed_in) begin
            pst_d = spp_pkg::SPP_PMP_OFF;
            pclr = 1'b1;
          end else if (pmp_if.cnt >= hs_lim) begin
            pst_d = spp_pkg::SPP_PMP_DUTY;
            pclr = 1'b1;
          end
        end
        spp_pkg::SPP_PMP_DUTY: begin
          if (auxn_q == 2'h2 && pmp_if.cnt >= alt_lim) begin
            pst_d = spp_pkg::SPP_PMP_LOCK;
            pclr = 1'b1;
          end
        end
        default: begin
          if (pmp_if.cnt >= lock_lim) begin
            pst_d = spp_pkg::SPP_PMP_DUTY;
            duty_d = ~duty_q;
            pclr = 1'b1;
            pswap = 1'b1;
          end
        end
      endcase
    end
    if (auxn_q == 2'h1) begin
      duty_d = 1'b0;
    end
  end
  assign pmp_if.tick = tick;
  assign pmp_if.en = 1'b1;
  assign pmp_if.clr = pclr;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pst_q <= spp_pkg::SPP_PMP_OFF;
      duty_q <= 1'b0;
      pump_q <= 2'h0;
    end else begin
      pst_q <= pst_d;
      duty_q <= duty_d;
      if (pst_d == spp_pkg::SPP_PMP_DUTY) begin
        pump_q <= duty_d ? 2'h2 : 2'h1;
      end else begin
        pump_q <= 2'h0;
      end
    end
  end

  always_comb begin
    ev = '0;
    ev[`SPP_EV_ALARM] = alarm_nx && !alarm_q;
    ev[`SPP_EV_TRIP] = trip_set && !trip_q;
    ev[`SPP_EV_STEP] = adv;
    ev[`SPP_EV_SWAP] = pswap;
    ev[`SPP_EV_STALL] = (acc_q || std_q || dec_q) && !stall_prev_q;
  end

  always_comb begin
    any_nz = 1'b0;
    for (int i = 0; i < 8; i++) begin
      any_nz = any_nz | (tmr_q[i] != 16'h0000);
    end
  end

  assign rd_data_out = rd_q;
  assign ramp_pair_out = ramp_q;
  assign step_freq_out = sfreq_q;
  assign step_index_out = step_q;
  assign accel_hold_out = acc_q;
  assign steady_lower_out = std_q;
  assign decel_hold_out = dec_q;
  assign ot_alarm_out = alarm_q;
  assign ot_trip_out = trip_q;
  assign drive_enable_out = run_in && !trip_q && !fault_in;
  assign pump_contact_out = pump_q;
  assign irq_out = |(sts_q & mask_q);

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  property p_ramp_field;
    seq_q == spp_pkg::SPP_SEQ_RUN && $stable(ramp_word_q)
      |-> ramp_pair_out == ramp_word_q[{step_q, 1'b0} +: 2];
  endproperty
  a_ramp_field: assert property (p_ramp_field) else $error("ramp pair mismatch");
  property p_prog_gate;
    prog_q != `SPP_PROG_INTERNAL |=> seq_q != spp_pkg::SPP_SEQ_RUN && ramp_pair_out == 2'h0;
  endproperty
  a_prog_gate: assert property (p_prog_gate) else $error("step ramp outside mode 4");
  property p_skip_zero;
    $changed(step_q) && seq_q == spp_pkg::SPP_SEQ_RUN && any_nz && !$past(wr_in)
      |-> tmr_q[step_q] != 16'h0000;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero timer step entered");
  property p_resume;
    seq_q == spp_pkg::SPP_SEQ_RUN && !run_ok
      |=> (seq_q == spp_pkg::SPP_SEQ_HOLD) == $past(resume_q) && (resume_q || step_q == 3'h0);
  endproperty
  a_resume: assert property (p_resume) else $error("resume memory mishandled");
  property p_decel;
    (dcbus_over_in && decel_in && ovs_q)[*4] |-> decel_hold_out;
  endproperty
  a_decel: assert property (p_decel) else $error("decel not paused on high bus");
  property p_accel;
    accel_in && accl_q == 8'h00 |=> !accel_hold_out;
  endproperty
  a_accel: assert property (p_accel) else $error("accel stall with zero level");
  property p_steady;
    steady_in && stdl_q == 8'h00 |=> !steady_lower_out;
  endproperty
  a_steady: assert property (p_steady) else $error("steady stall with zero level");
  property p_ot_alarm;
    $rose(ot_alarm_out) |-> $past({ot_if.cnt, 1'b0} > 25'(ottm_q));
  endproperty
  a_ot_alarm: assert property (p_ot_alarm) else $error("alarm before half time");
  property p_ot_clear;
    !ot_act |=> ot_if.cnt == 24'h000000 && !ot_alarm_out;
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("over-torque time not cleared");
  property p_trip_mode;
    $rose(ot_trip_out) |-> $past(otmd_q[0]) && $past(otlv_q) != 8'h00;
  endproperty
  a_trip_mode: assert property (p_trip_mode) else $error("trip in run-on mode");
  property p_pump_none;
    auxn_q == 2'h0 |=> pump_contact_out == 2'h0;
  endproperty
  a_pump_none: assert property (p_pump_none) else $error("contact with no pumps");
  property p_interlock;
    pst_q == spp_pkg::SPP_PMP_LOCK |-> pump_contact_out == 2'h0;
  endproperty
  a_interlock: assert property (p_interlock) else $error("contact during interlock");
  property p_hs_start;
    $past(pst_q) == spp_pkg::SPP_PMP_WAIT && pst_q == spp_pkg::SPP_PMP_DUTY
      |-> $past(pmp_if.cnt) >= $past(hs_lim) && pump_contact_out != 2'h0;
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("aux pump started early");

  c_step: cover property (adv && seq_q == spp_pkg::SPP_SEQ_RUN);
  c_alarm: cover property ($rose(ot_alarm_out));
  c_trip: cover property ($rose(ot_trip_out));
  c_swap: cover property (pswap);
endmodule // spp_top

/* File: test/spp_motor_model.sv */
`timescale 1ns/10ps
module spp_motor_model (
  input wire logic clk_sys_in,
  input wire logic en_in,
  input wire logic [7:0] load_in,
  output logic [7:0] current_pct_out
);
  // no current without output; one cycle lag like a real sensor path
  always_ff @(posedge clk_sys_in) begin
    current_pct_out <= en_in ? load_in : 8'h00;
  end
endmodule // spp_motor_model

/* File: test/spp_top_tb.sv */
`timescale 1ns/10ps
`include "spp_params.svh"
module spp_top_tb;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in, load, cur;
  logic [15:0] wr_data_in, main_freq_in, rd_data_out, step_freq_out, w;
  logic wr_in, rd_in, run_in, fault_in, accel_in, steady_in, decel_in;
  logic freq_reached_in, high_speed_in, dcbus_over_in, rd_seen;
  logic [1:0] ramp_pair_out, pump_contact_out;
  logic [2:0] step_index_out;
  logic accel_hold_out, steady_lower_out, decel_hold_out, ot_alarm_out;
  logic ot_trip_out, drive_enable_out, irq_out;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] ra[11] = '{8'h00, 8'h02, 8'h09, 8'h0b, 8'h12, 8'h13, 8'h18, 8'h1a, 8'h1b,
    8'h1c, 8'h20};
  logic [15:0] rv[11] = '{16'h0000, 16'h05dc, 16'h0064, 16'h0000, 16'h0001, 16'h0096,
    16'h000a, 16'h003c, 16'h0005, 16'h003c, 16'h0000};
  always #25 clk_sys_in = ~clk_sys_in;
  spp_top #(.TICK_CYCLES(4)) i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
    .rd_data_out(rd_data_out), .run_in(run_in), .fault_in(fault_in), .accel_in(accel_in),
    .steady_in(steady_in), .decel_in(decel_in), .freq_reached_in(freq_reached_in),
    .high_speed_in(high_speed_in), .current_pct_in(cur), .dcbus_over_in(dcbus_over_in),
    .main_freq_in(main_freq_in), .ramp_pair_out(ramp_pair_out),
    .step_freq_out(step_freq_out), .step_index_out(step_index_out),
    .accel_hold_out(accel_hold_out), .steady_lower_out(steady_lower_out),
    .decel_hold_out(decel_hold_out), .ot_alarm_out(ot_alarm_out),
    .ot_trip_out(ot_trip_out), .drive_enable_out(drive_enable_out),
    .pump_contact_out(pump_contact_out), .irq_out(irq_out));
  spp_motor_model i_motor (.clk_sys_in(clk_sys_in), .en_in(drive_enable_out),
    .load_in(load), .current_pct_out(cur));
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys_in);
  endtask
  // strobe dropped with an idle cycle so no signal is assigned twice per step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    cyc(1);
    wr_in <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_q.push_back(e);
    cyc(1);
    rd_in <= 1'b0;
    cyc(1);
  endtask
  task automatic wait_alarm;
    n = 0;
    while (ot_alarm_out !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
  endtask
  always @(posedge clk_sys_in) rd_seen <= rd_in;
  // read data stands only in the cycle after the strobe
  always @(negedge clk_sys_in) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      chk(rd_data_out, exp_q.pop_front());
    end
  end
  initial begin
    cyc(20000);
    err_total++;
    stop_test();
  end
  initial begin
    {addr_in, wr_data_in, wr_in, rd_in, run_in, fault_in, accel_in} = '0;
    {steady_in, decel_in, freq_reached_in, high_speed_in, dcbus_over_in} = '0;
    load = 8'hc8;
    void'($urandom(16));
    main_freq_in = 16'($urandom);
    cyc(12);
    rstn_in <= 1'b1;
    cyc(1);
    wr(8'h20, 16'hffff);
    for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
    wr(`SPP_A_OTTM, 16'h0004);
    wr(`SPP_A_MASK, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      wr(`SPP_A_OTLV, (i == 0) ? 16'h0000 : 16'h0064);
      wr(`SPP_A_OTMD, (i == 0) ? 16'h0002 : 16'(i - 1));
      run_in <= 1'b1;
      cyc(80);
      chk(ot_alarm_out, i == 3);
      chk(ot_trip_out, i == 4);
      chk(drive_enable_out, i != 4);
      run_in <= 1'b0;
      cyc(2);
    end
    freq_reached_in <= 1'b1;
    wr(`SPP_A_OTMD, 16'h0001);
    run_in <= 1'b1;
    cyc(80);
    chk(ot_trip_out, 1'b1);
    run_in <= 1'b0;
    wr(`SPP_A_OTMD, 16'h0002);
    run_in <= 1'b1;
    wait_alarm();
    chk(n >= 8 && n < 30, 1'b1);
    load <= 8'h00;
    cyc(4);
    chk(ot_alarm_out, 1'b0);
    load <= 8'hc8;
    wait_alarm();
    chk(n >= 8 && n < 30, 1'b1);
    run_in <= 1'b0;
    cyc(4);
    rd(`SPP_A_STS, 16'h0003);
    chk(irq_out, 1'b1);
    wr(`SPP_A_STS, 16'h001f);
    rd(`SPP_A_STS, 16'h0000);
    chk(irq_out, 1'b0);
    accel_in <= 1'b1;
    load <= 8'ha0;
    run_in <= 1'b1;
    cyc(4);
    chk(accel_hold_out, 1'b1);
    load <= 8'h8c;
    cyc(4);
    chk(accel_hold_out, 1'b0);
    wr(`SPP_A_ACCL, 16'h0000);
    load <= 8'ha0;
    cyc(4);
    chk(accel_hold_out, 1'b0);
    accel_in <= 1'b0;
    decel_in <= 1'b1;
    dcbus_over_in <= 1'b1;
    cyc(5);
    chk(decel_hold_out, 1'b1);
    wr(`SPP_A_OVS, 16'h0000);
    cyc(4);
    chk(decel_hold_out, 1'b0);
    decel_in <= 1'b0;
    steady_in <= 1'b1;
    cyc(4);
    chk(steady_lower_out, 1'b0);
    wr(`SPP_A_STDL, 16'h0078);
    cyc(4);
    chk(steady_lower_out, 1'b1);
    steady_in <= 1'b0;
    run_in <= 1'b0;
    w = 16'($urandom);
    wr(`SPP_A_RAMP, w);
    wr(`SPP_A_TMR1, 16'h0000);
    cyc(3);
    chk(ramp_pair_out, 2'h0);
    chk(step_freq_out, main_freq_in);
    wr(`SPP_A_PROG, 16'h0004);
    run_in <= 1'b1;
    cyc(4);
    chk(ramp_pair_out, w[3:2]);
    chk(step_index_out, 3'h1);
    chk(step_freq_out, 16'h05dc);
    wr(`SPP_A_HST, 16'h0001);
    wr(`SPP_A_LOCK, 16'h0001);
    wr(`SPP_A_ALT, 16'h0001);
    wr(`SPP_A_AUXN, 16'h0002);
    high_speed_in <= 1'b1;
    cyc(30);
    chk(pump_contact_out, 2'h0);
    cyc(20);
    chk(pump_contact_out, 2'h1);
    // duty lasts 600 ticks, then 10 ticks with both contacts open
    high_speed_in <= 1'b0;
    cyc(2410);
    chk(pump_contact_out, 2'h0);
    cyc(40);
    chk(pump_contact_out, 2'h2);
    wr(`SPP_A_AUXN, 16'h0000);
    cyc(2);
    chk(pump_contact_out, 2'h0);
    stop_test();
  end
endmodule // spp_top_tb
